// File: rtl/drive_telegram_pkg.sv
package drive_telegram_pkg;
  // =====================================================================
  // parameter commands and responses
  localparam logic [3:0] CMD_NONE = 4'h0;
  localparam logic [3:0] CMD_READ = 4'h1;
  localparam logic [3:0] CMD_WR_W = 4'h2;
  localparam logic [3:0] CMD_WR_D = 4'h3;
  localparam logic [3:0] CMD_WR_D_NV = 4'hd;
  localparam logic [3:0] CMD_WR_W_NV = 4'he;
  localparam logic [3:0] CMD_TEXT = 4'hf;
  localparam logic [3:0] RSP_NONE = 4'h0;
  localparam logic [3:0] RSP_WORD = 4'h1;
  localparam logic [3:0] RSP_DWORD = 4'h2;
  localparam logic [3:0] RSP_FAIL = 4'h7;
  localparam logic [3:0] RSP_TEXT = 4'hf;
  // =====================================================================
  // fault reports
  localparam logic [7:0] FLT_NO_PARAM = 8'h00;
  localparam logic [7:0] FLT_NO_WRITE = 8'h01;
  localparam logic [7:0] FLT_LIMIT = 8'h02;
  localparam logic [7:0] FLT_NO_INDEX = 8'h03;
  localparam logic [7:0] FLT_NOT_ARRAY = 8'h04;
  localparam logic [7:0] FLT_TYPE = 8'h05;
  localparam logic [6:0] FAULT_MAX = 7'h63;
  // =====================================================================
  // data types and conversion indices
  localparam logic [3:0] TYPE_S16 = 4'h3;
  localparam logic [3:0] TYPE_S32 = 4'h4;
  localparam logic [3:0] TYPE_U8 = 4'h5;
  localparam logic [3:0] TYPE_U16 = 4'h6;
  localparam logic [3:0] TYPE_U32 = 4'h7;
  localparam logic [3:0] TYPE_TEXT = 4'h9;
  localparam logic [7:0] CONV_X100 = 8'h02;
  localparam logic [7:0] CONV_X10 = 8'h01;
  localparam logic [7:0] CONV_X1 = 8'h00;
  localparam logic [7:0] CONV_D10 = 8'hff;
  localparam logic [7:0] CONV_D100K = 8'hfb;
  localparam logic [7:0] CONV_D10_ALT = 8'h49;
  // =====================================================================
  // word layouts
  localparam int CMD_LSB = 12;
  localparam int PNU_MSB = 10;
  localparam logic [10:0] ERR_PNU = 11'h267;
  localparam logic [7:0] TXT_RD = 8'h04;
  localparam logic [7:0] TXT_WR = 8'h05;
  localparam logic [7:0] LEN_PARAM = 8'h0e;
  localparam logic [7:0] TXT_BASE_LEN = 8'h0a;
  localparam int CW_DC = 2;
  localparam int CW_COAST = 3;
  localparam int CW_QSTOP = 4;
  localparam int CW_FREEZE = 5;
  localparam int CW_START = 6;
  localparam int CW_RESET = 7;
  localparam int CW_JOG = 8;
  localparam int CW_RAMP = 9;
  localparam int CW_VALID = 10;
  localparam int CW_SETUP_LSB = 13;
  localparam int CW_REV = 15;
  localparam logic [15:0] CW_RST = 16'h0080;
  // =====================================================================
  // gating of serial bits with digital inputs
  localparam logic [1:0] GATE_DIN = 2'h0;
  localparam logic [1:0] GATE_BUS = 2'h1;
  localparam logic [1:0] GATE_AND = 2'h2;
  localparam logic [1:0] GATE_OR = 2'h3;
  localparam int GATE_COAST_LSB = 0;
  localparam int GATE_DC_LSB = 2;
  localparam int GATE_START_LSB = 4;
  localparam int GATE_PRESET_LSB = 6;
  localparam logic [7:0] GATE_RST = 8'hff;
  localparam logic [7:0] PROFILE_NATIVE = 8'h01;
  localparam logic [7:0] PROFILE_RST = 8'h01;
  // =====================================================================
  // register map
  localparam logic [7:0] REG_PROFILE = 8'h00;
  localparam logic [7:0] REG_GATE = 8'h01;
  localparam logic [7:0] REG_STATUS = 8'h02;
  localparam logic [3:0] PAGE_VALUE = 4'h1;
  localparam logic [3:0] PAGE_ATTR = 4'h2;
  localparam logic [3:0] PAGE_FAULT = 4'h3;
  localparam int ATTR_CONV_LSB = 4;
  localparam int ATTR_WR = 12;
  localparam logic [12:0] ATTR_RST = 13'h1006;
endpackage

// File: rtl/drive_telegram_param_control.sv
`timescale 1ns/1ps
// Notes on behaviour
// - first parameter word: command/response code bits 15:12, parameter number bits 10:0.
// - value field is two 16-bit words; meaning follows the command code.
// - on writes the value field is the value to store.
// - read answers carry the parameter's present value.
// - option parameters carry the option ordinal; writing it selects the option.
// - indexed error-code parameter answers with a fault code 1 to 99.
// - text telegrams vary in length; the length byte is parsed and generated.
// - index word tells text read from text write.
// - data types 3,4,5,6,7 and 9 are supported; unsigned carries no sign.
// - values are whole numbers scaled by the parameter's conversion index.
// - process words: control then reference in, status then frequency out.
// - control word decoded only while the telegram profile setting is 1.
// - control bits 1:0 select one of four preset references.
// - clear bit 2 commands dc braking and stop.
// - clear bit 3 coasts at once; set bit 3 permits starting.
// - clear bit 4 is a quick stop on its own ramp.
// - clear bit 5 freezes the output frequency.
// - while frozen, start stops are ignored; only coast, quick stop or dc brake stop.
// - clear bit 6 ramps down; set bit 6 permits starting.
// - bit 7 clears a trip only on its rising transition.
// - dc brake, coast, start and preset bits gate with digital inputs by setting.
// - bits 8 jog, 9 ramp select, 10 valid, 13-14 setup, 15 reversing.
// - clear bit 10 ignores the control word, parameters still processed.
module drive_telegram_param_control #(
  parameter int NUM_PARAMS = 16,
  parameter int FAULT_DEPTH = 4
) (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic [7:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [31:0] reg_rdata,
  input wire logic tg_valid,
  input wire logic [7:0] telegram_length_byte,
  input wire logic [15:0] param_id_word,
  input wire logic [15:0] param_index_word,
  input wire logic [31:0] param_value_field,
  input wire logic [15:0] process_word_first,
  input wire logic [15:0] process_word_second,
  input wire logic [15:0] status_word,
  input wire logic [15:0] output_freq,
  input wire logic din_coast_n,
  input wire logic din_dc_brake_n,
  input wire logic din_reset_coast_n,
  input wire logic din_start,
  input wire logic [1:0] din_preset,
  output logic rsp_valid,
  output logic [7:0] rsp_length_byte,
  output logic [15:0] rsp_id_word,
  output logic [15:0] rsp_index_word,
  output logic [31:0] rsp_value_field,
  output logic [15:0] rsp_process_first,
  output logic [15:0] rsp_process_second,
  output logic [1:0] preset_sel,
  output logic dc_brake,
  output logic coast,
  output logic quick_stop,
  output logic freeze,
  output logic ramp_stop,
  output logic trip_reset,
  output logic jog,
  output logic ramp2_sel,
  output logic [1:0] setup_sel,
  output logic reverse,
  output logic [15:0] reference
);
  // parameter table is mapped one page of 16 words, so NUM_PARAMS stays <= 16
  localparam int PW = $clog2(NUM_PARAMS);
  localparam int FW = $clog2(FAULT_DEPTH);

  // =====================================================================
  // state
  typedef struct packed {
    logic [7:0] profile;
    logic [7:0] gate;
    logic [NUM_PARAMS-1:0][31:0] value;
    logic [NUM_PARAMS-1:0][12:0] attr;
    logic [FAULT_DEPTH-1:0][6:0] fault;
    logic [31:0] rdata;
    logic rsp_valid;
    logic [7:0] rsp_len;
    logic [15:0] rsp_id;
    logic [15:0] rsp_idx;
    logic [31:0] rsp_val;
    logic [15:0] rsp_pf;
    logic [15:0] rsp_ps;
    logic [3:0] last_code;
    logic [7:0] last_fault;
    logic [15:0] cw;
    logic [15:0] reference;
    logic trip_reset;
    logic [1:0] preset;
    logic dc_brake;
    logic coast;
    logic quick_stop;
    logic freeze;
    logic ramp_stop;
  } state_s;

  state_s st;
  state_s next_st;

  // =====================================================================
  // helpers
  function automatic logic gate_mix(input logic [1:0] mode, input logic bus, input logic din);
    logic r;
    r = din;
    unique case (mode)
      drive_telegram_pkg::GATE_DIN: r = din;
      drive_telegram_pkg::GATE_BUS: r = bus;
      drive_telegram_pkg::GATE_AND: r = bus & din;
      drive_telegram_pkg::GATE_OR: r = bus | din;
    endcase
    return r;
  endfunction

  function automatic logic is_dword(input logic [3:0] t);
    return (t == drive_telegram_pkg::TYPE_S32) || (t == drive_telegram_pkg::TYPE_U32);
  endfunction

  // word writes of a signed 16-bit type sign-extend; unsigned ones zero-fill
  function automatic logic [31:0] widen(input logic [3:0] t, input logic [15:0] w);
    return (t == drive_telegram_pkg::TYPE_S16) ? {{16{w[15]}}, w} : {16'h0000, w};
  endfunction

  function automatic logic fits(input logic [3:0] t, input logic [31:0] v);
    logic ok;
    ok = 1'b0;
    unique case (t)
      drive_telegram_pkg::TYPE_S16: ok = (v[31:15] == 17'h00000) || (v[31:15] == 17'h1ffff);
      drive_telegram_pkg::TYPE_U8: ok = (v[31:8] == 24'h000000);
      drive_telegram_pkg::TYPE_U16: ok = (v[31:16] == 16'h0000);
      drive_telegram_pkg::TYPE_S32: ok = 1'b1;
      drive_telegram_pkg::TYPE_U32: ok = 1'b1;
      default: ok = 1'b0;
    endcase
    return ok;
  endfunction

  // characters sit first-to-last from bit 31 down; a zero byte ends the text
  function automatic logic [7:0] text_chars(input logic [31:0] v);
    logic [7:0] n;
    logic stop;
    n = 8'h00;
    stop = 1'b0;
    for (int i = 0; i < 4; i++)
    begin
      if (v[31-8*i -: 8] == 8'h00)
        stop = 1'b1;
      else if (!stop)
        n = n + 8'h01;
    end
    return n;
  endfunction

  function automatic logic [31:0] text_mask(input logic [31:0] v, input logic [7:0] len);
    logic [7:0] n;
    logic [31:0] r;
    n = (len > drive_telegram_pkg::TXT_BASE_LEN) ? len - drive_telegram_pkg::TXT_BASE_LEN : 8'h00;
    r = 32'h0000_0000;
    for (int i = 0; i < 4; i++)
    begin
      if (8'(i) < n)
        r[31-8*i -: 8] = v[31-8*i -: 8];
    end
    return r;
  endfunction

  // =====================================================================
  // next state
  always_comb
  begin
    logic [3:0] cmd;
    logic [10:0] param_number_field;
    logic [7:0] idx;
    logic [PW-1:0] ent;
    logic exists;
    logic is_err;
    logic [3:0] ptype;
    logic wr_ok;
    logic word;
    logic fail;
    logic [7:0] fault;
    logic [3:0] code;
    logic [31:0] val;
    logic [31:0] wval;
    logic [7:0] len;
    logic [6:0] entry;
    logic coast_ok;
    logic dc_ok;
    logic start_ok;
    cmd = param_id_word[15:drive_telegram_pkg::CMD_LSB];
    param_number_field = param_id_word[drive_telegram_pkg::PNU_MSB:0];
    idx = param_index_word[7:0];
    ent = param_number_field[PW-1:0];
    exists = param_number_field < 11'(NUM_PARAMS);
    is_err = param_number_field == drive_telegram_pkg::ERR_PNU;
    ptype = exists ? st.attr[ent][3:0] : drive_telegram_pkg::TYPE_U8;
    wr_ok = exists & st.attr[ent][drive_telegram_pkg::ATTR_WR];
    word = (cmd == drive_telegram_pkg::CMD_WR_W) || (cmd == drive_telegram_pkg::CMD_WR_W_NV);
    fail = 1'b0;
    fault = drive_telegram_pkg::FLT_NO_PARAM;
    code = drive_telegram_pkg::RSP_NONE;
    val = 32'h0000_0000;
    wval = 32'h0000_0000;
    len = drive_telegram_pkg::LEN_PARAM;
    entry = 7'h00;
    next_st = st;
    next_st.rsp_valid = 1'b0;
    next_st.trip_reset = 1'b0;

    // software side; a telegram write in the same cycle overrides it
    if (reg_wr)
    begin
      if (reg_addr == drive_telegram_pkg::REG_PROFILE)
        next_st.profile = reg_wdata[7:0];
      else if (reg_addr == drive_telegram_pkg::REG_GATE)
        next_st.gate = reg_wdata[7:0];
      else if (reg_addr[7:4] == drive_telegram_pkg::PAGE_VALUE && reg_addr[3:0] <= 4'(NUM_PARAMS - 1))
        next_st.value[reg_addr[PW-1:0]] = reg_wdata;
      else if (reg_addr[7:4] == drive_telegram_pkg::PAGE_ATTR && reg_addr[3:0] <= 4'(NUM_PARAMS - 1))
        next_st.attr[reg_addr[PW-1:0]] = reg_wdata[12:0];
      else if (reg_addr[7:4] == drive_telegram_pkg::PAGE_FAULT && reg_addr[3:0] <= 4'(FAULT_DEPTH - 1))
        next_st.fault[reg_addr[FW-1:0]] = reg_wdata[6:0];
    end
    if (reg_rd)
    begin
      next_st.rdata = 32'h0000_0000;
      if (reg_addr == drive_telegram_pkg::REG_PROFILE)
        next_st.rdata = {24'h000000, st.profile};
      else if (reg_addr == drive_telegram_pkg::REG_GATE)
        next_st.rdata = {24'h000000, st.gate};
      else if (reg_addr == drive_telegram_pkg::REG_STATUS)
        next_st.rdata = {st.cw, st.last_code, 4'h0, st.last_fault};
      else if (reg_addr[7:4] == drive_telegram_pkg::PAGE_VALUE && reg_addr[3:0] <= 4'(NUM_PARAMS - 1))
        next_st.rdata = st.value[reg_addr[PW-1:0]];
      else if (reg_addr[7:4] == drive_telegram_pkg::PAGE_ATTR && reg_addr[3:0] <= 4'(NUM_PARAMS - 1))
        next_st.rdata = {19'h00000, st.attr[reg_addr[PW-1:0]]};
      else if (reg_addr[7:4] == drive_telegram_pkg::PAGE_FAULT && reg_addr[3:0] <= 4'(FAULT_DEPTH - 1))
        next_st.rdata = {25'h0000000, st.fault[reg_addr[FW-1:0]]};
    end

    // ===================================================================
    // parameter part
    if (tg_valid)
    begin
      if (cmd == drive_telegram_pkg::CMD_NONE)
        code = drive_telegram_pkg::RSP_NONE;
      else if (!exists && !is_err)
      begin
        fail = 1'b1;
        fault = drive_telegram_pkg::FLT_NO_PARAM;
      end
      else if (cmd == drive_telegram_pkg::CMD_TEXT)
      begin
        if (is_err || ptype != drive_telegram_pkg::TYPE_TEXT)
        begin
          fail = 1'b1;
          fault = drive_telegram_pkg::FLT_TYPE;
        end
        else if (param_index_word[15:8] == drive_telegram_pkg::TXT_RD)
        begin
          code = drive_telegram_pkg::RSP_TEXT;
          val = st.value[ent];
          len = drive_telegram_pkg::TXT_BASE_LEN + text_chars(val);
        end
        else if (param_index_word[15:8] == drive_telegram_pkg::TXT_WR)
        begin
          if (!wr_ok)
          begin
            fail = 1'b1;
            fault = drive_telegram_pkg::FLT_NO_WRITE;
          end
          else
          begin
            wval = text_mask(param_value_field, telegram_length_byte);
            next_st.value[ent] = wval;
            code = drive_telegram_pkg::RSP_TEXT;
            val = wval;
            len = drive_telegram_pkg::TXT_BASE_LEN + text_chars(wval);
          end
        end
        else
        begin
          fail = 1'b1;
          fault = drive_telegram_pkg::FLT_NO_INDEX;
        end
      end
      else if (is_err)
      begin
        entry = st.fault[FW'(idx - 8'h01)];
        if (cmd != drive_telegram_pkg::CMD_READ)
        begin
          fail = 1'b1;
          fault = drive_telegram_pkg::FLT_NO_WRITE;
        end
        else if (idx == 8'h00 || idx > 8'(FAULT_DEPTH) || entry == 7'h00
                 || entry > drive_telegram_pkg::FAULT_MAX)
        begin
          fail = 1'b1;
          fault = drive_telegram_pkg::FLT_NO_INDEX;
        end
        else
        begin
          code = drive_telegram_pkg::RSP_WORD;
          val = {25'h0000000, entry};
        end
      end
      else if (idx != 8'h00)
      begin
        fail = 1'b1;
        fault = drive_telegram_pkg::FLT_NOT_ARRAY;
      end
      else if (ptype == drive_telegram_pkg::TYPE_TEXT)
      begin
        fail = 1'b1;
        fault = drive_telegram_pkg::FLT_TYPE;
      end
      else if (cmd == drive_telegram_pkg::CMD_READ)
      begin
        // the incoming value field is don't-care on reads
        code = is_dword(ptype) ? drive_telegram_pkg::RSP_DWORD : drive_telegram_pkg::RSP_WORD;
        val = st.value[ent];
      end
      else if (word || cmd == drive_telegram_pkg::CMD_WR_D || cmd == drive_telegram_pkg::CMD_WR_D_NV)
      begin
        // non-volatile writes land in the same table; no separate store here
        wval = word ? widen(ptype, param_value_field[15:0]) : param_value_field;
        if (word == is_dword(ptype))
        begin
          fail = 1'b1;
          fault = drive_telegram_pkg::FLT_TYPE;
        end
        else if (!wr_ok)
        begin
          fail = 1'b1;
          fault = drive_telegram_pkg::FLT_NO_WRITE;
        end
        else if (!fits(ptype, wval))
        begin
          fail = 1'b1;
          fault = drive_telegram_pkg::FLT_LIMIT;
        end
        else
        begin
          // whole number kept as sent; scaling lives in the attribute word
          next_st.value[ent] = wval;
          code = word ? drive_telegram_pkg::RSP_WORD : drive_telegram_pkg::RSP_DWORD;
          val = wval;
        end
      end
      else
      begin
        fail = 1'b1;
        fault = drive_telegram_pkg::FLT_TYPE;
      end
      if (fail)
      begin
        code = drive_telegram_pkg::RSP_FAIL;
        val = {24'h000000, fault};
      end
      next_st.rsp_valid = 1'b1;
      next_st.rsp_len = len;
      next_st.rsp_id = {code, param_id_word[11:0]};
      next_st.rsp_idx = param_index_word;
      next_st.rsp_val = val;
      next_st.rsp_pf = status_word;
      next_st.rsp_ps = output_freq;
      next_st.last_code = code;
      next_st.last_fault = fail ? fault : st.last_fault;
    end

    // ===================================================================
    // process part
    if (tg_valid && st.profile == drive_telegram_pkg::PROFILE_NATIVE
        && process_word_first[drive_telegram_pkg::CW_VALID])
    begin
      next_st.cw = process_word_first;
      next_st.reference = process_word_second;
      next_st.trip_reset = process_word_first[drive_telegram_pkg::CW_RESET]
                           & ~st.cw[drive_telegram_pkg::CW_RESET];
    end

    coast_ok = gate_mix(st.gate[drive_telegram_pkg::GATE_COAST_LSB +: 2],
                        st.cw[drive_telegram_pkg::CW_COAST], din_coast_n) & din_reset_coast_n;
    dc_ok = gate_mix(st.gate[drive_telegram_pkg::GATE_DC_LSB +: 2],
                     st.cw[drive_telegram_pkg::CW_DC], din_dc_brake_n);
    start_ok = gate_mix(st.gate[drive_telegram_pkg::GATE_START_LSB +: 2],
                        st.cw[drive_telegram_pkg::CW_START], din_start);
    for (int i = 0; i < 2; i++)
    begin
      next_st.preset[i] = gate_mix(st.gate[drive_telegram_pkg::GATE_PRESET_LSB +: 2],
                                   st.cw[i], din_preset[i]);
    end
    // coast outranks dc brake: with the stage off there is nothing to brake
    next_st.coast = ~coast_ok;
    next_st.dc_brake = coast_ok & ~dc_ok;
    next_st.quick_stop = ~st.cw[drive_telegram_pkg::CW_QSTOP];
    next_st.freeze = ~st.cw[drive_telegram_pkg::CW_FREEZE];
    next_st.ramp_stop = ~start_ok & st.cw[drive_telegram_pkg::CW_FREEZE];
  end

  // =====================================================================
  // registers
  always_ff @(posedge clk)
  begin
    if (sys_rst)
    begin
      st <= '0;
      st.profile <= drive_telegram_pkg::PROFILE_RST;
      st.gate <= drive_telegram_pkg::GATE_RST;
      st.attr <= {NUM_PARAMS{drive_telegram_pkg::ATTR_RST}};
      st.cw <= drive_telegram_pkg::CW_RST;
      st.coast <= 1'b1;
      st.quick_stop <= 1'b1;
      st.ramp_stop <= 1'b1;
    end
    else
      st <= next_st;
  end

  // =====================================================================
  // outputs
  assign reg_rdata = st.rdata;
  assign rsp_valid = st.rsp_valid;
  assign rsp_length_byte = st.rsp_len;
  assign rsp_id_word = st.rsp_id;
  assign rsp_index_word = st.rsp_idx;
  assign rsp_value_field = st.rsp_val;
  assign rsp_process_first = st.rsp_pf;
  assign rsp_process_second = st.rsp_ps;
  assign preset_sel = st.preset;
  assign dc_brake = st.dc_brake;
  assign coast = st.coast;
  assign quick_stop = st.quick_stop;
  assign freeze = st.freeze;
  assign ramp_stop = st.ramp_stop;
  assign trip_reset = st.trip_reset;
  assign jog = st.cw[drive_telegram_pkg::CW_JOG];
  assign ramp2_sel = st.cw[drive_telegram_pkg::CW_RAMP];
  assign setup_sel = st.cw[drive_telegram_pkg::CW_SETUP_LSB +: 2];
  assign reverse = st.cw[drive_telegram_pkg::CW_REV];
  assign reference = st.reference;
endmodule

// File: bench/drive_telegram_master.sv
`timescale 1ns/1ps
// ==========
// telegram master
module drive_telegram_master (
  input wire logic clk,
  output logic tg_valid,
  output logic [7:0] telegram_length_byte,
  output logic [15:0] param_id_word,
  output logic [15:0] param_index_word,
  output logic [31:0] param_value_field,
  output logic [15:0] process_word_first,
  output logic [15:0] process_word_second
);
  initial {tg_valid, telegram_length_byte, param_id_word, param_index_word} = '0;
  initial {param_value_field, process_word_first, process_word_second} = '0;
  task automatic send(input logic [15:0] id, input logic [15:0] idx, input logic [31:0] v, input logic [15:0] cw);
    @(posedge clk);
    tg_valid <= 1'b1;
    telegram_length_byte <= drive_telegram_pkg::LEN_PARAM;
    param_id_word <= id;
    param_index_word <= idx;
    // reads carry junk to catch an echo
    param_value_field <= (id[15:12] == drive_telegram_pkg::CMD_READ) ? 32'h5a3c96e1 : v;
    process_word_first <= cw;
    process_word_second <= ~cw;
    @(posedge clk);
    tg_valid <= 1'b0;
    // stale fields toggle
    {param_id_word, param_index_word, param_value_field} <= ~{param_id_word, param_index_word, param_value_field};
  endtask
endmodule

// File: bench/drive_telegram_param_control_props.sv
`timescale 1ns/1ps
// ==========
// port checks
module drive_telegram_param_control_props (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic tg_valid,
  input wire logic [15:0] param_id_word,
  input wire logic [15:0] process_word_first,
  input wire logic [15:0] status_word,
  input wire logic [15:0] output_freq,
  input wire logic din_reset_coast_n,
  input wire logic rsp_valid,
  input wire logic [7:0] rsp_length_byte,
  input wire logic [15:0] rsp_id_word,
  input wire logic [31:0] rsp_value_field,
  input wire logic [15:0] rsp_process_first,
  input wire logic [15:0] rsp_process_second,
  input wire logic dc_brake,
  input wire logic coast,
  input wire logic trip_reset,
  input wire logic jog,
  input wire logic reverse
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);
  a_rsp_after_req: assert property (
    tg_valid |=> rsp_valid && rsp_id_word[11:0] == $past(param_id_word[11:0])) else $error("bad response");
  a_rsp_no_spurious: assert property (
    rsp_valid |-> $past(tg_valid)) else $error("stray response");
  a_process_echo: assert property (
    tg_valid |=> rsp_process_first == $past(status_word) && rsp_process_second == $past(output_freq))
    else $error("process words");
  a_param_length: assert property (
    tg_valid && param_id_word[15:12] != drive_telegram_pkg::CMD_TEXT |=> rsp_length_byte == 8'h0e)
    else $error("bad length byte");
  a_text_code: assert property (
    tg_valid && param_id_word[15:12] == drive_telegram_pkg::CMD_TEXT |=> rsp_id_word[15:12] inside {4'hf, 4'h7})
    else $error("text code");
  a_fault_range: assert property (
    rsp_valid && rsp_id_word[10:0] == drive_telegram_pkg::ERR_PNU && rsp_id_word[15:12] != 4'h7
    |-> rsp_value_field inside {[1:99]}) else $error("fault range");
  a_trip_edge: assert property (
    trip_reset |-> $past(tg_valid) && $past(process_word_first[7]) ##1 !trip_reset) else $error("bad trip reset");
  a_reset_coast: assert property (
    !din_reset_coast_n |=> coast) else $error("coast input");
  a_brake_coast: assert property (
    dc_brake |-> !coast) else $error("brake while coasting");
  a_ignore_word: assert property (
    tg_valid && !process_word_first[10] && !$past(tg_valid) && !$past(tg_valid, 2) |=> $stable({jog, reverse}))
    else $error("invalid word used");
endmodule
bind drive_telegram_param_control drive_telegram_param_control_props u_props (.*);

// File: bench/testbench.sv
`timescale 1ns/1ps
module testbench;
  logic clk, sys_rst, reg_wr, reg_rd, tg_valid, rsp_valid, din_reset_coast_n, dc_brake, coast, prof;
  logic quick_stop, freeze, ramp_stop, trip_reset, jog, ramp2_sel, reverse;
  logic [1:0] preset_sel, setup_sel;
  logic [7:0] reg_addr, telegram_length_byte, rsp_length_byte;
  logic [15:0] param_id_word, param_index_word, process_word_first, process_word_second, status_word;
  logic [15:0] output_freq, rsp_id_word, rsp_index_word, rsp_process_first, rsp_process_second, reference, last_cw;
  logic [31:0] reg_wdata, reg_rdata, param_value_field, rsp_value_field;
  logic [3:0] types [5] = '{4'h3, 4'h4, 4'h5, 4'h6, 4'h7};
  int err_count, n_tests;
  drive_telegram_param_control u_drive_telegram_param_control (.*, .din_coast_n(1'b1), .din_dc_brake_n(1'b1),
    .din_start(1'b1), .din_preset(2'h0));
  drive_telegram_master u_drive_telegram_master (.*);
  // ==========
  // tasks
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp)
    begin
      err_count++;
      $display("mismatch %0t: %h vs %h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clk);
    reg_wr <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] exp);
    @(posedge clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clk);
    reg_rd <= 1'b0;
    #1 chk(reg_rdata, exp);
  endtask
  function automatic logic [15:0] pid(input logic [3:0] c, input logic [10:0] n);
    return {c, 1'b0, n};
  endfunction
  task automatic tx(input logic [15:0] id, input logic [15:0] idx, input logic [31:0] v, input logic [3:0] code,
    input logic [31:0] ev);
    @(posedge clk);
    status_word <= id;
    output_freq <= ~id;
    u_drive_telegram_master.send(id, idx, v, 16'h0000);
    #1 chk({rsp_index_word[14:0], rsp_valid, rsp_id_word}, {idx[14:0], 1'b1, code, id[11:0]});
    chk(rsp_value_field, ev);
  endtask
  // bus-only gating: outputs follow the last accepted word
  task automatic ctl(input logic [15:0] cw);
    logic acc;
    acc = prof && cw[10];
    u_drive_telegram_master.send(16'h0000, 16'h0000, 32'h0, cw);
    #1 chk(32'(trip_reset), 32'(acc && cw[7] && !last_cw[7]));
    if (acc)
      last_cw = cw;
    @(posedge clk);
    #1 chk({preset_sel, dc_brake, coast, quick_stop, freeze, ramp_stop, jog, ramp2_sel, setup_sel, reverse,
      reference},
      {last_cw[1:0], last_cw[3] & ~last_cw[2], ~last_cw[3], ~last_cw[4], ~last_cw[5], ~last_cw[6] & last_cw[5],
      last_cw[8], last_cw[9], last_cw[14:13], last_cw[15], ~last_cw});
  endtask
  task automatic stop_test();
    $display("errors %0d checks %0d", err_count, n_tests);
    if (err_count == 0 && n_tests > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask
  // ==========
  // run
  initial
  begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  initial
  begin
    repeat (5000) @(posedge clk);
    err_count++;
    stop_test();
  end
  initial
  begin
    {reg_wr, reg_rd, reg_addr, reg_wdata, status_word, output_freq} = '0;
    {sys_rst, din_reset_coast_n, prof} = 3'b111;
    last_cw = drive_telegram_pkg::CW_RST;
    repeat (5) @(posedge clk);
    sys_rst <= 1'b0;
    rd(drive_telegram_pkg::REG_PROFILE, 32'h1);
    rd(drive_telegram_pkg::REG_GATE, 32'hff);
    rd(8'h20, 32'h1006);
    rd(8'hff, 32'h0);
    tx(pid(4'h2, 11'd3), 16'h0, 32'h64, 4'h1, 32'h64);
    tx(pid(4'h1, 11'd3), 16'h0, 32'h0, 4'h1, 32'h64);
    rd(8'h13, 32'h64);
    tx(pid(4'he, 11'd4), 16'h0, 32'h14, 4'h1, 32'h14);
    tx(pid(4'h3, 11'd4), 16'h0, 32'h14, 4'h7, 32'h5);
    tx(pid(4'h0, 11'd4), 16'h0, 32'h0, 4'h0, 32'h0);
    tx(pid(4'h1, 11'd100), 16'h0, 32'h0, 4'h7, 32'h0);
    tx(pid(4'h1, drive_telegram_pkg::ERR_PNU), 16'h1, 32'h0, 4'h7, 32'h3);
    tx(pid(4'hf, 11'd3), 16'h0400, 32'h0, 4'h7, 32'h5);
    // word writes for 8- and 16-bit types, dword writes for 32-bit types
    foreach (types[i])
    begin
      wr(8'h25, {19'h0, 1'b1, 8'h00, types[i]});
      tx(pid((types[i] inside {4'h4, 4'h7}) ? 4'hd : 4'h2, 11'd5), 16'h0, 32'h80,
        (types[i] inside {4'h4, 4'h7}) ? 4'h2 : 4'h1, 32'h80);
    end
    wr(8'h26, {19'h0, 1'b1, drive_telegram_pkg::CONV_D10_ALT, 4'h6});
    rd(8'h26, {19'h0, 1'b1, drive_telegram_pkg::CONV_D10_ALT, 4'h6});
    tx(pid(4'h2, 11'd6), 16'h0, 32'h3e8, 4'h1, 32'h3e8);
    wr(8'h22, {19'h0, 1'b1, 8'h00, drive_telegram_pkg::TYPE_TEXT});
    u_drive_telegram_master.send(pid(4'hf, 11'd2), 16'h0500, 32'h41424344, 16'h0);
    #1 chk(32'(rsp_id_word[15:12]), 32'hf);
    tx(pid(4'hf, 11'd2), 16'h0400, 32'h0, 4'hf, 32'h41424344);
    chk(32'(rsp_length_byte), 32'h0e);
    wr(drive_telegram_pkg::REG_GATE, 32'h55);
    for (int i = 0; i < 4; i++)
      ctl(16'h0478 | 16'(i));
    ctl(16'h0474);
    ctl(16'h0468);
    ctl(16'h041c);
    ctl(16'he7fc);
    ctl(16'he7fc);
    ctl(16'h0003);
    wr(drive_telegram_pkg::REG_PROFILE, 32'h0);
    prof = 1'b0;
    ctl(16'h047b);
    @(posedge clk);
    din_reset_coast_n <= 1'b0;
    @(posedge clk);
    #1 chk(32'(coast), 32'h1);
    stop_test();
  end
endmodule
